// [hdl/sfc_pkg.sv]
package sfc_pkg;
    // command opcodes
    localparam logic [7:0] CMD_READ        = 8'h03;
    localparam logic [7:0] CMD_FAST_READ   = 8'h0B;
    localparam logic [7:0] CMD_SECT_ERASE  = 8'h20;
    localparam logic [7:0] CMD_BLK32_ERASE = 8'h52;
    localparam logic [7:0] CMD_BLK64_ERASE = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERASE  = 8'h60;
    localparam logic [7:0] CMD_CHIP_ERASE2 = 8'hC7;
    localparam logic [7:0] CMD_BYTE_PROG   = 8'h02;
    localparam logic [7:0] CMD_AUTO_INC    = 8'hAD;
    localparam logic [7:0] CMD_STAT_READ   = 8'h05;
    localparam logic [7:0] CMD_STAT_WR_EN  = 8'h50;
    localparam logic [7:0] CMD_STAT_WRITE  = 8'h01;
    localparam logic [7:0] CMD_WRITE_EN    = 8'h06;
    localparam logic [7:0] CMD_WRITE_DIS   = 8'h04;
    localparam logic [7:0] CMD_ID_READ     = 8'h90;
    localparam logic [7:0] CMD_ID_READ2    = 8'hAB;
    localparam logic [7:0] CMD_JEDEC_ID    = 8'h9F;
    localparam logic [7:0] CMD_BUSY_OUT_EN = 8'h70;
    localparam logic [7:0] CMD_BUSY_OUT_DI = 8'h80;
    // status byte field positions
    localparam int ST_BUSY    = 0;
    localparam int ST_WLATCH  = 1;
    localparam int ST_PROT_LO = 2;
    localparam int ST_AUTOINC = 6;
    localparam int ST_LOCK    = 7;
    // reset values and the read underrun fill byte
    localparam logic [3:0] PROT_RST = 4'h7;
    localparam logic       LOCK_RST = 1'b0;
    localparam logic [3:0] PIN_IDLE = 4'hA;
    localparam logic [7:0] UNDERRUN = 8'hFF;
    // array geometry and protected region bases
    localparam logic [18:0] ADDR_MAX  = 19'h7FFFF;
    localparam logic [18:0] PROT_BASE1 = 19'h70000;
    localparam logic [18:0] PROT_BASE2 = 19'h60000;
    localparam logic [18:0] PROT_BASE3 = 19'h40000;
    localparam logic [19:0] WORD_STEP = 20'h00002;

    typedef enum logic [5:0] {
        S_OPC = 6'h01, S_ADDR = 6'h02, S_DUMMY = 6'h04,
        S_DIN = 6'h08, S_DOUT = 6'h10, S_SKIP  = 6'h20
    } sfc_state_t;

    typedef enum logic [2:0] {
        K_PROG = 3'h0, K_WORD = 3'h1, K_SECT = 3'h2,
        K_BLK32 = 3'h3, K_BLK64 = 3'h4, K_CHIP = 3'h5
    } sfc_kind_t;

    typedef struct packed {
        sfc_kind_t   kind;
        logic [18:0] addr;
        logic [15:0] data;
    } sfc_op_t;

    // true when the address lies in the protected region
    function automatic logic sfc_is_prot(input logic [2:0] bp, input logic [18:0] a);
        case (bp)
            3'h0:    return 1'b0;
            3'h1:    return a >= PROT_BASE1;
            3'h2:    return a >= PROT_BASE2;
            3'h3:    return a >= PROT_BASE3;
            default: return 1'b1;
        endcase
    endfunction : sfc_is_prot
endpackage : sfc_pkg

// [hdl/sfc_buf.sv]
`timescale 1ns/100ps
module sfc_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rstn,
    input  wire logic                     i_flush,
    input  wire logic                     i_valid,
    output logic                          o_ready,
    input  wire logic [WIDTH-1:0]         i_data,
    output logic                          o_valid,
    input  wire logic                     i_ready,
    output logic [WIDTH-1:0]              o_data,
    output logic [$clog2(DEPTH+1)-1:0]    o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("sfc_buf: DEPTH must be a power of two, at least 2");
    end

    // handshakes and levels
    assign o_ready = count != CW'(DEPTH);
    assign o_valid = count != '0;
    assign push    = i_valid & o_ready;
    assign pop     = i_ready & o_valid;
    assign o_data  = mem[rd_ptr];
    assign o_level = count;

    // pointers and occupancy, flush empties the buffer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + AW'(1);
            if (pop) rd_ptr <= rd_ptr + AW'(1);
            if (push && !pop) count <= count + CW'(1);
            else if (pop && !push) count <= count - CW'(1);
        end
    end

    // storage words
    always_ff @(posedge i_clk) begin
        if (push && !i_flush) mem[wr_ptr] <= i_data;
    end
endmodule : sfc_buf

// [hdl/sfc_top.sv]
`timescale 1ns/100ps
module sfc_top #(
    parameter logic [7:0]  MAKER_ID  = 8'h5A,      // arbitrary value
    parameter logic [7:0]  PART_ID   = 8'hC3,      // arbitrary value
    parameter logic [23:0] JEDEC_ID  = 24'h5AC301, // arbitrary value
    parameter int          BUF_DEPTH = 2
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_sck,
    input  wire logic        i_cs_n,
    input  wire logic        i_si,
    input  wire logic        i_wp_n,
    output logic             o_so,
    output logic             o_so_oe_n,
    output logic [7:0]       o_status,
    output logic             o_op_valid,
    output sfc_pkg::sfc_op_t o_op,
    input  wire logic        i_op_done,
    output logic             o_rd_req_valid,
    input  wire logic        i_rd_req_ready,
    output logic [18:0]      o_rd_addr,
    input  wire logic        i_rd_valid,
    output logic             o_rd_ready,
    input  wire logic [7:0]  i_rd_data
);
    localparam int LW = $clog2(BUF_DEPTH+1);

    if (BUF_DEPTH < 2) begin : g_chk
        $error("sfc_top: BUF_DEPTH must be at least 2");
    end

    sfc_pkg::sfc_state_t st;
    sfc_pkg::sfc_kind_t  ikind;
    logic [3:0]  pin_meta, pin_s;
    logic        sck_s, cs_s, si_s, wp_s, sck_d, cs_d;
    logic        sck_rise, sck_fall, cs_rise, byte_end;
    logic [7:0]  rx, next_rx, opcode, fetch, tx;
    logic [2:0]  bitcnt, ocnt;
    logic [1:0]  bytecnt, dcnt, jidx;
    logic [23:0] addr, addr_full;
    logic [15:0] data;
    logic        extra, addr_done, is_read, out_load, id_sel;
    logic        rd_on, rd_pend, buf_valid;
    logic [7:0]  buf_data;
    logic [LW-1:0] buf_level;
    logic        write_latch_bit, busy, auto_increment_program, aai_end, bsy_en, status_write_enable_cmd_arm, lock, init_q;
    logic [3:0]  prot;
    logic [18:0] aai_addr, word_base, iaddr;
    logic [19:0] word_next;
    logic        commit, tail_ok, wr_ok, issue, wsr_go;

    // two-stage synchronisers for every pin
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_meta <= sfc_pkg::PIN_IDLE;
            pin_s    <= sfc_pkg::PIN_IDLE;
            sck_d    <= 1'b0;
            cs_d     <= 1'b1;
        end else begin
            pin_meta <= {i_wp_n, i_si, i_cs_n, i_sck};
            pin_s    <= pin_meta;
            sck_d    <= sck_s;
            cs_d     <= cs_s;
        end
    end

    // edges found on the synchronised serial clock and select
    assign {wp_s, si_s, cs_s, sck_s} = pin_s;
    assign sck_rise  = sck_s & ~sck_d & ~cs_s;
    assign sck_fall  = ~sck_s & sck_d & ~cs_s;
    assign cs_rise   = cs_s & ~cs_d;
    assign next_rx   = {rx[6:0], si_s};
    assign byte_end  = sck_rise && bitcnt == 3'h7;
    assign addr_full = {addr[15:0], next_rx};
    assign addr_done = byte_end && st == sfc_pkg::S_ADDR && bytecnt == 2'h2;
    assign is_read   = opcode == sfc_pkg::CMD_READ || opcode == sfc_pkg::CMD_FAST_READ;

    // phase after the opcode byte
    function automatic sfc_pkg::sfc_state_t opc_next(input logic [7:0] op, input logic inc);
        case (op)
            sfc_pkg::CMD_READ, sfc_pkg::CMD_FAST_READ, sfc_pkg::CMD_SECT_ERASE,
            sfc_pkg::CMD_BLK32_ERASE, sfc_pkg::CMD_BLK64_ERASE, sfc_pkg::CMD_BYTE_PROG,
            sfc_pkg::CMD_ID_READ, sfc_pkg::CMD_ID_READ2: return sfc_pkg::S_ADDR;
            sfc_pkg::CMD_AUTO_INC:   return inc ? sfc_pkg::S_DIN : sfc_pkg::S_ADDR;
            sfc_pkg::CMD_STAT_WRITE: return sfc_pkg::S_DIN;
            sfc_pkg::CMD_STAT_READ, sfc_pkg::CMD_JEDEC_ID: return sfc_pkg::S_DOUT;
            default:                 return sfc_pkg::S_SKIP;
        endcase
    endfunction : opc_next

    // phase after the third address byte
    function automatic sfc_pkg::sfc_state_t adr_next(input logic [7:0] op);
        case (op)
            sfc_pkg::CMD_FAST_READ: return sfc_pkg::S_DUMMY;
            sfc_pkg::CMD_READ, sfc_pkg::CMD_ID_READ, sfc_pkg::CMD_ID_READ2:
                return sfc_pkg::S_DOUT;
            sfc_pkg::CMD_BYTE_PROG, sfc_pkg::CMD_AUTO_INC: return sfc_pkg::S_DIN;
            default:                return sfc_pkg::S_SKIP;
        endcase
    endfunction : adr_next

    // command receiver, held idle while select is high
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st      <= sfc_pkg::S_OPC;
            rx      <= 8'h00;
            bitcnt  <= 3'h0;
            bytecnt <= 2'h0;
            opcode  <= 8'h00;
            addr    <= 24'h000000;
            data    <= 16'h0000;
            dcnt    <= 2'h0;
            extra   <= 1'b0;
        end else if (cs_s) begin
            st      <= sfc_pkg::S_OPC;
            bitcnt  <= 3'h0;
            bytecnt <= 2'h0;
        end else if (sck_rise) begin
            rx     <= next_rx;
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
                case (st)
                    sfc_pkg::S_OPC: begin
                        opcode  <= next_rx;
                        st      <= opc_next(next_rx, auto_increment_program);
                        bytecnt <= 2'h0;
                        dcnt    <= 2'h0;
                        extra   <= 1'b0;
                    end
                    sfc_pkg::S_ADDR: begin
                        addr    <= addr_full;
                        bytecnt <= bytecnt + 2'h1;
                        if (bytecnt == 2'h2) st <= adr_next(opcode);
                    end
                    sfc_pkg::S_DUMMY: st <= sfc_pkg::S_DOUT;
                    sfc_pkg::S_DIN: begin
                        data <= {data[7:0], next_rx};
                        if (dcnt != 2'h3) dcnt <= dcnt + 2'h1;
                    end
                    sfc_pkg::S_SKIP: extra <= 1'b1;
                    default: st <= st;
                endcase
            end
        end
    end

    // byte source for the output shifter
    always_comb begin
        case (opcode)
            sfc_pkg::CMD_STAT_READ: fetch = o_status;
            sfc_pkg::CMD_JEDEC_ID:  fetch = JEDEC_ID[8*(2-jidx) +: 8];
            sfc_pkg::CMD_ID_READ, sfc_pkg::CMD_ID_READ2:
                fetch = id_sel ? PART_ID : MAKER_ID;
            default: fetch = buf_valid ? buf_data : sfc_pkg::UNDERRUN;
        endcase
    end
    assign out_load = sck_fall && st == sfc_pkg::S_DOUT && ocnt == 3'h0;

    // output shifter, advanced on falling serial clock
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx     <= 8'h00;
            ocnt   <= 3'h0;
            jidx   <= 2'h0;
            id_sel <= 1'b0;
        end else if (cs_s) begin
            ocnt <= 3'h0;
            jidx <= 2'h0;
        end else begin
            if (addr_done) id_sel <= addr_full[0];
            if (sck_fall && st == sfc_pkg::S_DOUT) begin
                ocnt <= ocnt + 3'h1;
                tx   <= out_load ? fetch : {tx[6:0], 1'b0};
                if (out_load) jidx <= (jidx == 2'h2) ? 2'h0 : jidx + 2'h1;
            end
        end
    end

    // read prefetch toward the array, one request outstanding
    assign o_rd_req_valid = rd_on && !rd_pend && buf_level < LW'(BUF_DEPTH);
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_on     <= 1'b0;
            rd_pend   <= 1'b0;
            o_rd_addr <= 19'h00000;
        end else begin
            if (i_rd_valid) rd_pend <= 1'b0;
            if (cs_s) begin
                rd_on <= 1'b0;
            end else if (addr_done && is_read) begin
                rd_on     <= 1'b1;
                o_rd_addr <= addr_full[18:0];
            end else if (o_rd_req_valid && i_rd_req_ready) begin
                rd_pend   <= 1'b1;
                o_rd_addr <= o_rd_addr + 19'h1;
            end
        end
    end

    // BUF_DEPTH-entry read data buffer
    sfc_buf #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .i_clk   (i_ref_clk),
        .i_rstn  (i_rstn),
        .i_flush (cs_s | addr_done),
        .i_valid (i_rd_valid),
        .o_ready (o_rd_ready),
        .i_data  (i_rd_data),
        .o_valid (buf_valid),
        .i_ready (out_load && is_read),
        .o_data  (buf_data),
        .o_level (buf_level)
    );

    // commit decision when select rises on a byte boundary
    assign commit    = cs_rise && bitcnt == 3'h0;
    assign tail_ok   = st == sfc_pkg::S_SKIP && !extra;
    assign wr_ok     = write_latch_bit && !busy && (!auto_increment_program || opcode == sfc_pkg::CMD_AUTO_INC);
    assign word_base = auto_increment_program ? aai_addr : {addr[18:1], 1'b0};
    assign word_next = {1'b0, word_base} + sfc_pkg::WORD_STEP;
    assign wsr_go    = commit && opcode == sfc_pkg::CMD_STAT_WRITE && st == sfc_pkg::S_DIN
                       && dcnt == 2'h1 && (write_latch_bit || status_write_enable_cmd_arm) && !busy && !auto_increment_program;
    always_comb begin
        issue = 1'b0;
        ikind = sfc_pkg::K_PROG;
        iaddr = addr[18:0];
        if (commit && wr_ok) begin
            case (opcode)
                sfc_pkg::CMD_BYTE_PROG: issue = st == sfc_pkg::S_DIN && dcnt == 2'h1
                    && !sfc_pkg::sfc_is_prot(prot[2:0], addr[18:0]);
                sfc_pkg::CMD_AUTO_INC: begin
                    ikind = sfc_pkg::K_WORD;
                    iaddr = word_base;
                    issue = st == sfc_pkg::S_DIN && dcnt == 2'h2
                        && !sfc_pkg::sfc_is_prot(prot[2:0], word_base);
                end
                sfc_pkg::CMD_SECT_ERASE, sfc_pkg::CMD_BLK32_ERASE, sfc_pkg::CMD_BLK64_ERASE: begin
                    ikind = opcode == sfc_pkg::CMD_SECT_ERASE ? sfc_pkg::K_SECT :
                            opcode == sfc_pkg::CMD_BLK32_ERASE ? sfc_pkg::K_BLK32 :
                            sfc_pkg::K_BLK64;
                    issue = tail_ok && !sfc_pkg::sfc_is_prot(prot[2:0], addr[18:0]);
                end
                sfc_pkg::CMD_CHIP_ERASE, sfc_pkg::CMD_CHIP_ERASE2: begin
                    ikind = sfc_pkg::K_CHIP;
                    issue = tail_ok && prot[2:0] == 3'h0;
                end
                default: issue = 1'b0;
            endcase
        end
    end

    // status bits and operation issue; later assignments win, so sets beat clears
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            write_latch_bit <= 1'b0;
            busy <= 1'b0;
            auto_increment_program <= 1'b0;
            aai_end <= 1'b0;
            bsy_en <= 1'b0;
            status_write_enable_cmd_arm <= 1'b0;
            lock <= sfc_pkg::LOCK_RST;
            prot <= sfc_pkg::PROT_RST;
            aai_addr <= 19'h00000;
            o_op_valid <= 1'b0;
            o_op <= '0;
        end else begin
            o_op_valid <= issue;
            if (i_op_done) begin
                busy <= 1'b0;
                if (o_op.kind != sfc_pkg::K_WORD || aai_end) write_latch_bit <= 1'b0;
                if (aai_end) auto_increment_program <= 1'b0;
            end
            if (commit) begin
                status_write_enable_cmd_arm <= 1'b0;
                case (opcode)
                    sfc_pkg::CMD_WRITE_EN:    if (tail_ok && !auto_increment_program) write_latch_bit <= 1'b1;
                    sfc_pkg::CMD_WRITE_DIS: if (tail_ok) begin
                        write_latch_bit <= 1'b0;
                        auto_increment_program <= 1'b0;
                    end
                    sfc_pkg::CMD_STAT_WR_EN:  if (tail_ok) status_write_enable_cmd_arm <= 1'b1;
                    sfc_pkg::CMD_BUSY_OUT_EN: if (tail_ok) bsy_en <= 1'b1;
                    sfc_pkg::CMD_BUSY_OUT_DI: if (tail_ok) bsy_en <= 1'b0;
                    default: status_write_enable_cmd_arm <= 1'b0;
                endcase
            end
            if (wsr_go) begin
                write_latch_bit <= 1'b0;
                if (wp_s || !lock) begin
                    prot <= data[sfc_pkg::ST_PROT_LO +: 4];
                    lock <= data[sfc_pkg::ST_LOCK];
                end
            end
            if (issue) begin
                busy <= 1'b1;
                o_op <= '{kind: ikind, addr: iaddr, data: data};
                if (ikind == sfc_pkg::K_WORD) begin
                    auto_increment_program      <= 1'b1;
                    aai_addr <= word_next[18:0];
                    aai_end  <= word_next[19] ||
                                sfc_pkg::sfc_is_prot(prot[2:0], word_next[18:0]);
                end
            end
        end
    end

    // status byte view
    assign o_status[sfc_pkg::ST_BUSY]         = busy;
    assign o_status[sfc_pkg::ST_WLATCH]       = write_latch_bit;
    assign o_status[sfc_pkg::ST_PROT_LO +: 4] = prot;
    assign o_status[sfc_pkg::ST_AUTOINC]      = auto_increment_program;
    assign o_status[sfc_pkg::ST_LOCK]         = lock;

    // serial output and its enable, low while driving
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_so      <= 1'b0;
            o_so_oe_n <= 1'b1;
            init_q    <= 1'b1;
        end else begin
            init_q    <= 1'b0;
            o_so      <= st == sfc_pkg::S_DOUT ? tx[7] : ~busy;
            o_so_oe_n <= cs_s || !(st == sfc_pkg::S_DOUT || (bsy_en && auto_increment_program));
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    chk_lock_hold: assert property (!wp_s && lock |=> lock && $stable(prot))
        else $error("protect bits changed while locked");
    chk_wp_open: assert property (wsr_go && wp_s |=>
        prot == $past(data[sfc_pkg::ST_PROT_LO +: 4]))
        else $error("status write refused with write-protect high");
    chk_lock_reset: assert property (init_q |-> lock == sfc_pkg::LOCK_RST)
        else $error("lock bit not clear after reset");
    chk_prot_reset: assert property (init_q |-> prot == sfc_pkg::PROT_RST && !write_latch_bit)
        else $error("protect bits wrong after reset");
    chk_abort_idle: assert property (cs_rise && bitcnt != 3'h0 |=>
        !o_op_valid && st == sfc_pkg::S_OPC)
        else $error("partial byte did not abandon command");
    chk_op_latch: assert property (o_op_valid |-> $past(write_latch_bit) && !$past(busy))
        else $error("operation issued without write latch");
    chk_prot_skip: assert property (o_op_valid && o_op.kind == sfc_pkg::K_PROG |->
        !sfc_pkg::sfc_is_prot(prot[2:0], o_op.addr))
        else $error("program issued to protected address");
    chk_busy_set: assert property (o_op_valid && !i_op_done |->
        o_status[sfc_pkg::ST_BUSY] ##1 (o_status[sfc_pkg::ST_BUSY] || $past(i_op_done)))
        else $error("busy not shown during operation");
    chk_addr_wrap: assert property (o_rd_req_valid && i_rd_req_ready && !cs_s
        && o_rd_addr == sfc_pkg::ADDR_MAX |=> o_rd_addr == 19'h00000)
        else $error("read address did not wrap");
    chk_bit_shift: assert property (sck_rise |=> rx == {$past(rx[6:0]), $past(si_s)})
        else $error("input bit not shifted msb first");
    chk_wdis_clear: assert property (commit && tail_ok
        && opcode == sfc_pkg::CMD_WRITE_DIS |=> !write_latch_bit && !auto_increment_program)
        else $error("write disable left latch set");

    cov_read_pop: cover property (out_load && is_read && buf_valid);
    cov_op_issue: cover property (o_op_valid ##[1:200] i_op_done);
    cov_abort:    cover property (cs_rise && bitcnt != 3'h0);
endmodule : sfc_top

// [testbench/sfc_mem_model.sv]
`timescale 1ns/100ps
module sfc_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic [18:0] i_addr,
    input  wire logic        i_op,
    output logic             o_valid = 1'b0,
    output logic [7:0]       o_data = 8'h00,
    output logic             o_done = 1'b0
);
    logic [5:0] dly = 6'h00;
    // one byte per request, else a changing pattern; done 64 cycles after launch
    always @(posedge i_clk) begin
        o_valid <= i_req & ~o_valid;
        o_data  <= i_req & ~o_valid ? i_addr[7:0] ^ 8'h5A : ~o_data;
        o_done  <= dly == 6'h01;
        dly     <= i_op ? 6'h3F : dly - 6'(dly != 6'h00);
    end
endmodule : sfc_mem_model

// [testbench/testbench.sv]
`timescale 1ns/100ps
`define CK(x, y) begin n_tests++; if ((x) !== (y)) begin n_mismatch++; \
    $display("wrong value %0t %h %h", $time, x, y); end end
module testbench;
    logic             clk = 1'b0, rstn = 1'b0, sck = 1'b1, cs_n = 1'b1, si = 1'b0;
    logic             wp_n = 1'b1, so, oe_n, opv, rqv, rv, done, rrdy;
    logic [7:0]       st, rd, b, d, rx[$];
    logic [18:0]      ra, a;
    logic [31:0]      seed = 32'hF82D1E1F;
    logic [7:0]       ec[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
    logic [18:0]      pb[4] = '{19'h70000, 19'h60000, 19'h40000, 19'h00000};
    int               n_mismatch = 0, n_tests = 0, n_op = 0;
    sfc_pkg::sfc_op_t op;
    sfc_top DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(oe_n), .o_status(st), .o_op_valid(opv),
        .o_op(op), .i_op_done(done), .o_rd_req_valid(rqv), .i_rd_req_ready(~rv),
        .o_rd_addr(ra), .i_rd_valid(rv), .o_rd_ready(rrdy), .i_rd_data(rd));
    sfc_mem_model MEM (.i_clk(clk), .i_req(rqv), .i_addr(ra), .i_op(opv), .o_valid(rv),
        .o_data(rd), .o_done(done));
    // clock and launch count
    always #2.5 clk = ~clk;
    always @(posedge clk) if (opv === 1'b1) n_op++;
    function automatic logic [7:0] ex(input logic [18:0] x);
        return x[7:0] ^ 8'h5A;
    endfunction : ex
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    // one frame of nb bytes, mode 3, select raised after cut bits
    task automatic cm(input logic [63:0] v, input int nb, input int cut);
        rx = {};
        cs_n <= 1'b0;
        w(4);
        for (int k = nb * 8 - 1; k >= nb * 8 - cut && k >= 0; k--) begin
            sck <= 1'b0;
            si <= v[k];
            w(16);
            b = {b[6:0], so};
            sck <= 1'b1;
            w(16);
            if (k % 8 == 0) rx.push_back(b);
        end
        w(8);
        cs_n <= 1'b1;
        w(16);
    endtask : cm
    task automatic ws(input logic [7:0] s);
        cm(64'h06, 1, 99);
        cm({8'h01, s}, 2, 99);
    endtask : ws
    task automatic pg(input logic [18:0] x);
        cm(64'h06, 1, 99);
        d = 8'(rnd());
        cm({8'h02, 5'h00, x, d}, 5, 99);
    endtask : pg
    task automatic summarize();
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        w(4);
        rstn <= 1'b1;
        w(4);
        `CK(st, 8'h1C)
        cm(64'h06, 1, 4);
        cm(64'hFF, 1, 99);
        `CK(st, 8'h1C)
        ws(8'h80);
        `CK(st, 8'h80)
        wp_n <= 1'b0;
        ws(8'h00);
        `CK(st[7:2], 6'h20)
        wp_n <= 1'b1;
        ws(8'h00);
        `CK(st, 8'h00)
        cm(64'h06, 1, 99);
        cm(64'h04, 1, 99);
        a = 19'(rnd());
        cm({8'h02, 5'h00, a, 8'h00}, 5, 99);
        `CK(n_op, 0)
        pg(a);
        `CK({op.kind, op.addr, op.data[7:0]}, {sfc_pkg::K_PROG, a, d})
        `CK(st[1:0], 2'h3)
        w(60);
        `CK(st, 8'h00)
        foreach (ec[i]) begin
            cm(64'h06, 1, 99);
            cm(i < 3 ? {ec[i], 5'h00, a} : ec[i], i < 3 ? 4 : 1, 99);
            `CK(op.kind, 3'(i < 3 ? i + 2 : 5))
            w(60);
        end
        for (int j = 0; j < 4; j++) begin
            ws(8'(j * 4 + 4));
            pg(pb[j] + 19'(rnd() & 32'hFFF));
            `CK(n_op, 6 + j)
            pg(pb[j] - 19'h1);
            `CK(n_op, j < 3 ? 7 + j : 9)
            w(60);
        end
        cm({8'h03, 24'h07FFFE, 24'h0}, 7, 99);
        `CK({rx[4], rx[5], rx[6]}, {ex(19'h7FFFE), ex(19'h7FFFF), ex(19'h0)})
        cm({8'h0B, 5'h00, a, 8'(rnd()), 16'h0}, 7, 99);
        `CK({rx[5], rx[6]}, {ex(a), ex(a + 19'h1)})
        cm(64'h050000, 3, 99);
        `CK({rx[1], rx[2]}, 16'h1212)
        cm({8'h90, 24'h000001, 16'h0}, 6, 99);
        `CK({rx[4], rx[5]}, 16'hC3C3)
        cm(64'h9F000000, 4, 99);
        `CK({rx[1], rx[2], rx[3]}, 24'h5AC301)
        cm(64'h04, 1, 99);
        cm(64'h50, 1, 99);
        cm(64'h0100, 2, 99);
        `CK(st, 8'h00)
        a = a & 19'h3FFFE;
        cm(64'h70, 1, 99);
        cm(64'h06, 1, 99);
        cm({8'hAD, 5'h00, a, 16'hA55A}, 6, 99);
        `CK({op.kind, op.addr, op.data, st[6]}, {sfc_pkg::K_WORD, a, 16'hA55A, 1'b1})
        cs_n <= 1'b0;
        w(8);
        `CK({oe_n, so}, 2'b00)
        cs_n <= 1'b1;
        w(60);
        cm(64'hAD1234, 3, 99);
        `CK({op.addr, op.data}, {a + 19'h2, 16'h1234})
        w(60);
        cm(64'h04, 1, 99);
        cm(64'h80, 1, 99);
        `CK({st, n_op, rrdy, rqv, oe_n}, {8'h00, 32'd11, 3'b101})
        summarize();
    end
endmodule : testbench
